// ===== src/stcp_pkg.sv
// Package for the 16-bit standard timer with compare and PWM.
// Shared by the bus slave, the tick generator and the timer core.
package stcp_pkg;
   localparam int unsigned ADDR_W     = 8;
   localparam int unsigned CLK_NS     = 10;
   // Register word indexes; byte address is four times the index
   localparam logic [5:0]  IDX_CTRL0  = 6'h00;
   localparam logic [5:0]  IDX_CTRL1  = 6'h01;
   localparam logic [5:0]  IDX_CNT_LO = 6'h02;
   localparam logic [5:0]  IDX_CNT_HI = 6'h03;
   localparam logic [5:0]  IDX_CCA_LO = 6'h04;
   localparam logic [5:0]  IDX_CCA_HI = 6'h05;
   localparam logic [5:0]  IDX_COMPARE_P_VALUE   = 6'h06;
   localparam logic [5:0]  IDX_STATUS = 6'h07;
   // Control 0 fields
   localparam int unsigned C0_PAUSE   = 7;
   localparam int unsigned C0_CLK_LO  = 4;
   localparam int unsigned C0_ENABLE  = 3;
   // Control 1 fields
   localparam int unsigned C1_MODE_LO = 6;
   localparam int unsigned C1_FUNC_LO = 4;
   localparam int unsigned C1_OC      = 3;
   localparam int unsigned C1_POL     = 2;
   localparam int unsigned C1_SWAP    = 1;
   localparam int unsigned C1_CLRSEL  = 0;
   // Status fields, write one to clear
   localparam int unsigned ST_FLAG_A  = 0;
   localparam int unsigned ST_FLAG_P  = 1;
   localparam logic [7:0]  REG_RST    = 8'h00;
   localparam logic [15:0] CNT_RST    = 16'h0000;
   // Modes and pin functions
   localparam logic [1:0]  MODE_CMP   = 2'b00;
   localparam logic [1:0]  MODE_CAP   = 2'b01;
   localparam logic [1:0]  MODE_PWM   = 2'b10;
   localparam logic [1:0]  MODE_TMR   = 2'b11;
   localparam logic [1:0]  FN_NONE    = 2'b00;
   localparam logic [1:0]  FN_LOW     = 2'b01;
   localparam logic [1:0]  FN_HIGH    = 2'b10;
   localparam logic [1:0]  FN_TOGGLE  = 2'b11;
   // Tick sources
   localparam logic [2:0]  TK_DIV4    = 3'b000;
   localparam logic [2:0]  TK_SYS     = 3'b001;
   localparam logic [2:0]  TK_DIV16   = 3'b010;
   localparam logic [2:0]  TK_DIV64   = 3'b011;
   localparam logic [2:0]  TK_SUB0    = 3'b100;
   localparam logic [2:0]  TK_SUB1    = 3'b101;
   localparam logic [2:0]  TK_EXT_R   = 3'b110;
   localparam logic [2:0]  TK_EXT_F   = 3'b111;
   localparam logic [16:0] FULL_SPAN  = 17'h10000;

   // Length in ticks set by the 8-bit period value
   function automatic logic [16:0] stcp_span(input logic [7:0] p);
      stcp_span = (p == 8'h00) ? FULL_SPAN : {1'b0, p, 8'h00};
   endfunction : stcp_span
endpackage : stcp_pkg

// ===== src/stcp_reg_if.sv
// Register access path between the bus slave and the timer core.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface stcp_reg_if;
   logic        wr_en;
   logic [5:0]  wr_idx;
   logic [7:0]  wr_data;
   logic [5:0]  rd_idx;
   logic [31:0] rd_data;
   modport bus  (output wr_en, wr_idx, wr_data, rd_idx, input rd_data);
   modport core (input wr_en, wr_idx, wr_data, rd_idx, output rd_data);
endinterface : stcp_reg_if
`default_nettype wire

// ===== src/stcp_tick.sv
// Timer tick generator: picks one of the counting rates.
// Assumes the system clock also serves as the high-speed clock.
`timescale 1ns/1ps
`default_nettype none
module stcp_tick import stcp_pkg::*; #(
   parameter logic [15:0] SUB_DIV = 16'd8
) (
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic [2:0] sel_in,
   input  wire logic       ext_clk_in,
   output logic            tick_out
);
   typedef struct packed {
      logic [5:0]  pre;
      logic [15:0] sub;
      logic        ext_q;
      logic        tick;
   } stcp_tick_type;
   stcp_tick_type r_reg, r_next;
   logic          sub_hit;

   always_comb begin
      sub_hit = (r_reg.sub == SUB_DIV - 16'd1);
      r_next = r_reg;
      r_next.pre = r_reg.pre + 6'd1;
      r_next.sub = sub_hit ? 16'd0 : r_reg.sub + 16'd1;
      r_next.ext_q = ext_clk_in;
      case (sel_in)
         TK_DIV4:  r_next.tick = &r_reg.pre[1:0];
         TK_SYS:   r_next.tick = 1'b1;
         TK_DIV16: r_next.tick = &r_reg.pre[3:0];
         TK_DIV64: r_next.tick = &r_reg.pre;
         TK_EXT_R: r_next.tick = ext_clk_in & ~r_reg.ext_q;
         TK_EXT_F: r_next.tick = ~ext_clk_in & r_reg.ext_q;
         default:  r_next.tick = sub_hit;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end
   assign tick_out = r_reg.tick;
endmodule : stcp_tick
`default_nettype wire

// ===== src/stcp_axi.sv
// AXI4-Lite slave for the timer byte registers.
// Data sits in bits 7..0; writes need byte lane 0 enabled.
`timescale 1ns/1ps
`default_nettype none
module stcp_axi import stcp_pkg::*; (
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   input  wire logic [ADDR_W-1:0] awaddr_in,
   input  wire logic              awvalid_in,
   output logic                   awready_out,
   input  wire logic [31:0]       wdata_in,
   input  wire logic [3:0]        wstrb_in,
   input  wire logic              wvalid_in,
   output logic                   wready_out,
   output logic                   bvalid_out,
   input  wire logic              bready_in,
   input  wire logic [ADDR_W-1:0] araddr_in,
   input  wire logic              arvalid_in,
   output logic                   arready_out,
   output logic [31:0]            rdata_out,
   output logic                   rvalid_out,
   input  wire logic              rready_in,
   stcp_reg_if.bus                regs
);
   typedef struct packed {
      logic [5:0]  aidx;
      logic        aw_full;
      logic        awready;
      logic [7:0]  wdat;
      logic        wlane;
      logic        w_full;
      logic        wready;
      logic        bvalid;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
   } stcp_axi_type;
   stcp_axi_type r_reg, r_next;
   logic         do_write;

   function automatic logic [5:0] word_idx(input logic [ADDR_W-1:0] a);
      word_idx = a[ADDR_W-1:2];
   endfunction : word_idx

   assign do_write     = r_reg.aw_full & r_reg.w_full & ~r_reg.bvalid;
   assign regs.wr_en   = do_write & r_reg.wlane;
   assign regs.wr_idx  = r_reg.aidx;
   assign regs.wr_data = r_reg.wdat;
   assign regs.rd_idx  = word_idx(araddr_in);

   always_comb begin
      r_next = r_reg;
      if (awvalid_in && r_reg.awready) begin
         r_next.aidx = word_idx(awaddr_in);
         r_next.aw_full = 1'b1;
         r_next.awready = 1'b0;
      end
      if (wvalid_in && r_reg.wready) begin
         r_next.wdat = wdata_in[7:0];
         r_next.wlane = wstrb_in[0];
         r_next.w_full = 1'b1;
         r_next.wready = 1'b0;
      end
      if (do_write) begin
         r_next.bvalid = 1'b1;
         r_next.aw_full = 1'b0;
         r_next.w_full = 1'b0;
      end
      // Hold both address and data channels until the response is taken
      if (r_reg.bvalid && bready_in) begin
         r_next.bvalid = 1'b0;
         r_next.awready = 1'b1;
         r_next.wready = 1'b1;
      end
      if (arvalid_in && r_reg.arready) begin
         r_next.rdata = regs.rd_data;
         r_next.rvalid = 1'b1;
         r_next.arready = 1'b0;
      end
      if (r_reg.rvalid && rready_in) begin
         r_next.rvalid = 1'b0;
         r_next.arready = 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         r_reg <= '0;
         r_reg.awready <= 1'b1;
         r_reg.wready <= 1'b1;
         r_reg.arready <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign awready_out = r_reg.awready;
   assign wready_out  = r_reg.wready;
   assign bvalid_out  = r_reg.bvalid;
   assign arready_out = r_reg.arready;
   assign rvalid_out  = r_reg.rvalid;
   assign rdata_out   = r_reg.rdata;
endmodule : stcp_axi
`default_nettype wire

// ===== src/stcp_timer.sv
// Top of the 16-bit standard timer: counter, compare A and P, PWM.
// Assumes AXI4-Lite master on CORE_CLK_IN; pin level resolved outside.
`timescale 1ns/1ps
`default_nettype none
module stcp_timer import stcp_pkg::*; #(
   parameter logic [15:0] SUB_DIV = 16'd8
) (
   // Clock and reset
   input  wire logic              CORE_CLK_IN,
   input  wire logic              RESET_N_IN,
   // AXI4-Lite write
   input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_IN,
   input  wire logic              S_AXI_AWVALID_IN,
   output logic                   S_AXI_AWREADY_OUT,
   input  wire logic [31:0]       S_AXI_WDATA_IN,
   input  wire logic [3:0]        S_AXI_WSTRB_IN,
   input  wire logic              S_AXI_WVALID_IN,
   output logic                   S_AXI_WREADY_OUT,
   output logic [1:0]             S_AXI_BRESP_OUT,
   output logic                   S_AXI_BVALID_OUT,
   input  wire logic              S_AXI_BREADY_IN,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN,
   input  wire logic              S_AXI_ARVALID_IN,
   output logic                   S_AXI_ARREADY_OUT,
   output logic [31:0]            S_AXI_RDATA_OUT,
   output logic [1:0]             S_AXI_RRESP_OUT,
   output logic                   S_AXI_RVALID_OUT,
   input  wire logic              S_AXI_RREADY_IN,
   // Timer pins
   input  wire logic              EXT_CLK_IN,
   output logic                   TIMER_PIN_OUT,
   output logic                   TIMER_PIN_OE_OUT
);
   typedef struct packed {
      logic [15:0] cnt;
      logic [15:0] cca;
      logic [7:0]  compare_p_value;
      logic        pause;
      logic [2:0]  clk_sel;
      logic        enable;
      logic [7:0]  ctl1;
      logic        flag_a;
      logic        flag_p;
      logic        pin_lvl;
      logic        pin;
      logic        pin_oe;
   } stcp_state_type;

   stcp_state_type r_reg, r_next;
   logic [1:0]     rst_sync_reg;
   logic           rst_n;
   logic           tick;
   logic           run, rise, a_hit, p_hit, clr, ev_a, ev_p, full, active, pwm_lvl;
   logic [1:0]     mode, func;
   logic           oc, pol, swap, clr_sel;
   logic [16:0]    per_len, duty_len;
   stcp_reg_if     regs ();

   // Asynchronous assert, synchronous release
   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   stcp_axi u_axi (
      .clk_in      (CORE_CLK_IN),
      .rst_n_in    (rst_n),
      .awaddr_in   (S_AXI_AWADDR_IN),
      .awvalid_in  (S_AXI_AWVALID_IN),
      .awready_out (S_AXI_AWREADY_OUT),
      .wdata_in    (S_AXI_WDATA_IN),
      .wstrb_in    (S_AXI_WSTRB_IN),
      .wvalid_in   (S_AXI_WVALID_IN),
      .wready_out  (S_AXI_WREADY_OUT),
      .bvalid_out  (S_AXI_BVALID_OUT),
      .bready_in   (S_AXI_BREADY_IN),
      .araddr_in   (S_AXI_ARADDR_IN),
      .arvalid_in  (S_AXI_ARVALID_IN),
      .arready_out (S_AXI_ARREADY_OUT),
      .rdata_out   (S_AXI_RDATA_OUT),
      .rvalid_out  (S_AXI_RVALID_OUT),
      .rready_in   (S_AXI_RREADY_IN),
      .regs        (regs.bus)
   );
   assign S_AXI_BRESP_OUT = 2'b00;
   assign S_AXI_RRESP_OUT = 2'b00;

   stcp_tick #(.SUB_DIV(SUB_DIV)) u_tick (
      .clk_in     (CORE_CLK_IN),
      .rst_n_in   (rst_n),
      .sel_in     (r_reg.clk_sel),
      .ext_clk_in (EXT_CLK_IN),
      .tick_out   (tick)
   );

   assign mode    = r_reg.ctl1[C1_MODE_LO +: 2];
   assign func    = r_reg.ctl1[C1_FUNC_LO +: 2];
   assign oc      = r_reg.ctl1[C1_OC];
   assign pol     = r_reg.ctl1[C1_POL];
   assign swap    = r_reg.ctl1[C1_SWAP];
   assign clr_sel = r_reg.ctl1[C1_CLRSEL];

   // Live read view; unmapped words read zero
   always_comb begin
      regs.rd_data = 32'h0000_0000;
      case (regs.rd_idx)
         IDX_CTRL0:  regs.rd_data[7:0] = {r_reg.pause, r_reg.clk_sel, r_reg.enable, 3'b000};
         IDX_CTRL1:  regs.rd_data[7:0] = r_reg.ctl1;
         IDX_CNT_LO: regs.rd_data[7:0] = r_reg.cnt[7:0];
         IDX_CNT_HI: regs.rd_data[7:0] = r_reg.cnt[15:8];
         IDX_CCA_LO: regs.rd_data[7:0] = r_reg.cca[7:0];
         IDX_CCA_HI: regs.rd_data[7:0] = r_reg.cca[15:8];
         IDX_COMPARE_P_VALUE:   regs.rd_data[7:0] = r_reg.compare_p_value;
         IDX_STATUS: regs.rd_data[1:0] = {r_reg.flag_p, r_reg.flag_a};
         default:    regs.rd_data = 32'h0000_0000;
      endcase
   end

   always_comb begin
      r_next = r_reg;
      // Register writes; counter bytes ignore writes
      if (regs.wr_en) begin
         case (regs.wr_idx)
            IDX_CTRL0: begin
               r_next.pause   = regs.wr_data[C0_PAUSE];
               r_next.clk_sel = regs.wr_data[C0_CLK_LO +: 3];
               r_next.enable  = regs.wr_data[C0_ENABLE];
            end
            IDX_CTRL1:  r_next.ctl1 = regs.wr_data;
            IDX_CCA_LO: r_next.cca[7:0] = regs.wr_data;
            IDX_CCA_HI: r_next.cca[15:8] = regs.wr_data;
            IDX_COMPARE_P_VALUE:   r_next.compare_p_value = regs.wr_data;
            IDX_STATUS: begin
               r_next.flag_a = r_reg.flag_a & ~regs.wr_data[ST_FLAG_A];
               r_next.flag_p = r_reg.flag_p & ~regs.wr_data[ST_FLAG_P];
            end
            default: r_next.ctl1 = r_reg.ctl1;
         endcase
      end
      rise = r_next.enable & ~r_reg.enable;
      run  = r_reg.enable & ~r_reg.pause & tick;
      // Matches fire on the last count so periods come out exact
      a_hit = (r_reg.cnt == r_reg.cca - 16'h0001);
      p_hit = (r_reg.cnt[15:8] == r_reg.compare_p_value - 8'h01) &&
              (r_reg.cnt[7:0] == 8'hff);
      if (mode == MODE_PWM) begin
         clr = swap ? a_hit : p_hit;
      end else begin
         clr = clr_sel ? a_hit : p_hit;
      end
      ev_a = run & a_hit;
      ev_p = run & p_hit & ((mode == MODE_PWM) | ~clr_sel);
      // Enable rise restarts; enable low keeps the residual count
      if (rise) begin
         r_next.cnt = CNT_RST;
      end else if (run) begin
         r_next.cnt = clr ? CNT_RST : r_reg.cnt + 16'h0001;
      end
      // Event beats a same-cycle clear
      if (ev_a) begin
         r_next.flag_a = 1'b1;
      end
      if (ev_p) begin
         r_next.flag_p = 1'b1;
      end
      // Compare-mode pin level, loaded from OC on enable rise, then moved only by compare A
      if (rise) begin
         r_next.pin_lvl = r_next.ctl1[C1_OC];
      end else if (ev_a && mode == MODE_CMP) begin
         case (func)
            FN_LOW:    r_next.pin_lvl = 1'b0;
            FN_HIGH:   r_next.pin_lvl = 1'b1;
            FN_TOGGLE: r_next.pin_lvl = ~r_reg.pin_lvl;
            default:   r_next.pin_lvl = r_reg.pin_lvl;
         endcase
      end
      per_len  = swap ? {1'b0, r_reg.cca} : stcp_span(r_reg.compare_p_value);
      duty_len = swap ? stcp_span(r_reg.compare_p_value) : {1'b0, r_reg.cca};
      full     = (duty_len >= per_len);
      active   = full | ({1'b0, r_reg.cnt} < duty_len);
      // Single pulse is not built here; it rests inactive
      case (func)
         FN_LOW:  pwm_lvl = oc;
         FN_HIGH: pwm_lvl = active ? oc : ~oc;
         default: pwm_lvl = ~oc;
      endcase
      case (mode)
         MODE_CMP: begin
            r_next.pin    = r_reg.pin_lvl ^ pol;
            r_next.pin_oe = 1'b1;
         end
         MODE_PWM: begin
            r_next.pin    = pwm_lvl ^ pol;
            r_next.pin_oe = 1'b1;
         end
         default: begin
            r_next.pin    = 1'b0;
            r_next.pin_oe = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign TIMER_PIN_OUT    = r_reg.pin;
   assign TIMER_PIN_OE_OUT = r_reg.pin_oe;

   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (!rst_n);

   sequence s_enable_rise;
      $rose(r_reg.enable);
   endsequence
   sequence s_p_clear;
      run && p_hit && mode != MODE_PWM && !clr_sel;
   endsequence

   a_rise_zero_count: assert property (s_enable_rise |-> r_reg.cnt == 16'h0000)
      else $error("counter not zero after enable rise");
   a_rise_init_pin: assert property (s_enable_rise |-> r_reg.pin_lvl == oc)
      else $error("pin level not initial after enable rise");
   a_pause_freeze: assert property (r_reg.pause && r_reg.enable |=>
         r_reg.cnt == $past(r_reg.cnt) || $rose(r_reg.enable))
      else $error("counter moved while paused");
   a_count_step: assert property (run && !clr && !regs.wr_en |=>
         r_reg.cnt == $past(r_reg.cnt) + 16'h0001)
      else $error("counter did not step by one");
   a_p_clear_flag: assert property (s_p_clear ##0 !regs.wr_en |=>
         r_reg.cnt == 16'h0000 && r_reg.flag_p)
      else $error("compare P did not clear and flag");
   a_no_p_flag: assert property (mode == MODE_CMP && clr_sel && !r_reg.flag_p &&
         !regs.wr_en |=> !r_reg.flag_p)
      else $error("compare P flag raised with clear select high");
   a_pin_only_a: assert property (mode == MODE_CMP && !ev_a && !$rose(r_next.enable) |=>
         $stable(r_reg.pin_lvl))
      else $error("pin moved without compare A event");
   a_timer_no_drive: assert property (mode == MODE_TMR ##1 mode == MODE_TMR |->
         !TIMER_PIN_OE_OUT)
      else $error("pin driven in timer mode");
   a_pwm_full_duty: assert property (mode == MODE_PWM && func == FN_HIGH && full |=>
         TIMER_PIN_OUT == ($past(oc) ^ $past(pol)))
      else $error("full duty not held active");
   a_pwm_forced: assert property (mode == MODE_PWM && func == FN_NONE |=>
         TIMER_PIN_OUT == (~$past(oc) ^ $past(pol)))
      else $error("forced inactive level wrong");
   a_off_hold: assert property (!r_reg.enable && !regs.wr_en |=> $stable(r_reg.cnt))
      else $error("counter moved while disabled");
   a_a_clear_flag: assert property (run && a_hit && mode != MODE_PWM && clr_sel &&
         !regs.wr_en |=> r_reg.cnt == 16'h0000 && r_reg.flag_a)
      else $error("compare A did not clear and flag");
endmodule : stcp_timer
`default_nettype wire

// ===== tb/stcp_pin_load.sv
// Load on the timer pin: a pull-down plus an edge timing monitor.
// Assumes the pin flops change just after the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module stcp_pin_load (
   // Clock and pin
   input  wire logic        clk_in,
   input  wire logic        pin_in,
   input  wire logic        oe_in,
   // Line level and last measured times
   output logic             lvl_out,
   output logic [31:0]      per_out,
   output logic [31:0]      hi_out
);
   logic [31:0] cyc_reg  = '0;
   logic [31:0] rise_reg = '0;
   logic [31:0] per_reg  = '0;
   logic [31:0] hi_reg   = '0;
   logic        prev_reg = 1'b0;
   // Undriven line sinks through the pull-down, never floats
   assign lvl_out = oe_in ? pin_in : 1'b0;
   assign per_out = per_reg;
   assign hi_out  = hi_reg;
   always @(posedge clk_in) begin
      cyc_reg  <= cyc_reg + 32'h1;
      prev_reg <= lvl_out;
      if (lvl_out && !prev_reg) begin
         per_reg  <= cyc_reg - rise_reg;
         rise_reg <= cyc_reg;
      end
      if (!lvl_out && prev_reg) begin
         hi_reg <= cyc_reg - rise_reg;
      end
   end
endmodule : stcp_pin_load
`default_nettype wire

// ===== tb/tb_stcp_timer.sv
// Bench for the timer: AXI4-Lite master, pin load and self checks.
// Assumes SUB_DIV of 2 and the system clock as the count tick.
`timescale 1ns/1ps
`default_nettype none
module tb_stcp_timer import stcp_pkg::*; ;
   logic        clk, awr, wr_rdy, bv, arr, rv, pin, oe, lvl;
   logic        rst_n = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
   logic [7:0]  awa = '0, ara = '0;
   logic [3:0]  strb = 4'h1;
   logic [31:0] wd = '0, rdat, per, hi, d, r;
   logic [1:0]  bresp, rresp;
   int          err_count = 0, total_checks = 0, cycles = 0;
   integer      seed = 32'h433f;
   logic        ext = 1'b0;
   localparam int SUB_N = 2;

   stcp_timer #(.SUB_DIV(16'(SUB_N))) i_dut (
      .CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv),
      .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(strb),
      .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wr_rdy), .S_AXI_BRESP_OUT(bresp),
      .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br), .S_AXI_ARADDR_IN(ara),
      .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdat),
      .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rr),
      .EXT_CLK_IN(ext), .TIMER_PIN_OUT(pin), .TIMER_PIN_OE_OUT(oe));
   stcp_pin_load i_load (.clk_in(clk), .pin_in(pin), .oe_in(oe), .lvl_out(lvl),
      .per_out(per), .hi_out(hi));

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk
   // Handshakes are judged on the settled half cycle before the taking edge
   task automatic wr(input logic [5:0] idx, input logic [7:0] v);
      logic a_hs, w_hs, b_hs;
      @(posedge clk);
      awa <= {idx, 2'b00};
      wd  <= {24'h0, v};
      awv <= 1'b1;
      wv  <= 1'b1;
      br  <= 1'b1;
      b_hs = 1'b0;
      while (!b_hs) begin
         @(negedge clk);
         a_hs = awv && awr;
         w_hs = wv && wr_rdy;
         b_hs = bv && br;
         @(posedge clk);
         if (a_hs) awv <= 1'b0;
         if (w_hs) wv <= 1'b0;
         if (b_hs) br <= 1'b0;
      end
      chk("write response", 32'h0, {30'h0, bresp});
   endtask : wr
   task automatic rd(input logic [5:0] idx, output logic [31:0] v);
      logic a_hs, r_hs;
      @(posedge clk);
      ara <= {idx, 2'b00};
      arv <= 1'b1;
      rr  <= 1'b1;
      r_hs = 1'b0;
      while (!r_hs) begin
         @(negedge clk);
         a_hs = arv && arr;
         r_hs = rv && rr;
         v = rdat;
         @(posedge clk);
         if (a_hs) arv <= 1'b0;
         if (r_hs) rr <= 1'b0;
      end
      chk("read response", 32'h0, {30'h0, rresp});
   endtask : rd
   // Stop, clear flags, load compares and mode, then restart on the system tick
   task automatic setup(input logic [7:0] c1, input logic [15:0] a, input logic [7:0] p);
      wr(IDX_CTRL0, 8'h10);
      wr(IDX_STATUS, 8'h03);
      wr(IDX_CCA_LO, a[7:0]);
      wr(IDX_CCA_HI, a[15:8]);
      wr(IDX_COMPARE_P_VALUE, p);
      wr(IDX_CTRL1, c1);
      wr(IDX_CTRL0, 8'h18);
   endtask : setup
   function automatic logic [31:0] span(input logic [7:0] p);
      span = (p == 8'h00) ? 32'h10000 : {16'h0, p, 8'h00};
   endfunction : span
   // Ticks in a 192-cycle window; external clock has an 8-cycle period
   function automatic logic [7:0] ticks(input logic [2:0] s);
      case (s)
         TK_SYS:           ticks = 8'd192;
         TK_DIV4:          ticks = 8'd48;
         TK_DIV16:         ticks = 8'd12;
         TK_DIV64:         ticks = 8'd3;
         TK_SUB0, TK_SUB1: ticks = 8'(192 / SUB_N);
         default:          ticks = 8'd24;
      endcase
   endfunction : ticks
   // Bits are {oc, pol, swap, clrsel}; high time follows the active level
   function automatic logic [31:0] pwm_hi(input logic [15:0] a, input logic [7:0] p,
                                          input logic [3:0] b);
      logic [31:0] pr;
      logic [31:0] dt;
      pr = b[1] ? {16'h0, a} : span(p);
      dt = b[1] ? span(p) : {16'h0, a};
      pwm_hi = (b[3] ^ b[2]) ? dt : pr - dt;
   endfunction : pwm_hi
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_of_test

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      forever begin
         @(posedge clk);
         cycles++;
         ext <= cycles[2];
         if (cycles == 95000) begin
            err_count++;
            $display("[ERR] run length expected 95000 seen more");
            end_of_test();
         end
      end
   end

   initial begin
      logic [5:0]  ix [6];
      logic [7:0]  ev [6];
      logic [1:0]  fc [3];
      logic [15:0] ta [5];
      logic [7:0]  tp [5];
      logic [3:0]  tb [5];
      logic        oc;
      fc = '{FN_LOW, FN_NONE, FN_HIGH};
      ta = '{16'd64, 16'd600, 16'd64, 16'd64, 16'd0};
      tp = '{8'h01, 8'h02, 8'h01, 8'h01, 8'h01};
      tb = '{4'b1000, 4'b1010, 4'b1100, 4'b0000, 4'b1000};
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
         rd(6'(i), d);
         chk("reset value", 32'h0, d);
      end
      r  = $random(seed);
      ix = '{IDX_CCA_LO, IDX_CCA_HI, IDX_COMPARE_P_VALUE, IDX_CNT_LO, IDX_CNT_HI, 6'h0a};
      ev = '{r[7:0], r[15:8], r[23:16], 8'h00, 8'h00, 8'h00};
      foreach (ix[i]) wr(ix[i], (i < 3) ? ev[i] : (r[31:24] | 8'h01));
      strb <= 4'h0;
      wr(IDX_COMPARE_P_VALUE, ~r[23:16]);
      strb <= 4'h1;
      foreach (ix[i]) begin
         rd(ix[i], d);
         chk("register access", {24'h0, ev[i]}, d);
      end
      $display("test registers done");
      foreach (fc[i]) begin
         oc = (fc[i] != FN_HIGH);
         setup({MODE_CMP, fc[i], oc, 3'b001}, 16'd40, 8'h01);
         @(negedge clk);
         chk("initial level", oc, lvl);
         repeat (100) @(posedge clk);
         chk("match level", (fc[i] == FN_NONE) ? oc : fc[i][1], lvl);
      end
      setup({MODE_CMP, FN_TOGGLE, 4'b0001}, 16'd10, 8'h01);
      repeat (300) @(posedge clk);
      chk("toggle period", 32'd20, per);
      rd(IDX_STATUS, d);
      chk("flags clear on A", 32'h1, d);
      rd(IDX_CNT_LO, d);
      chk("count below A", 32'h1, d < 32'd10);
      setup({MODE_CMP, FN_TOGGLE, 4'b0000}, 16'd5, 8'h01);
      repeat (1600) @(posedge clk);
      chk("toggle period", 32'd512, per);
      rd(IDX_STATUS, d);
      chk("flags clear on P", 32'h3, d);
      $display("test compare done");
      ta[4][7:0] = 8'($random(seed)) | 8'h01;
      for (int i = 0; i < 5; i++) begin
         setup({MODE_PWM, 2'b10, tb[i]}, ta[i], tp[i]);
         repeat (2000) @(posedge clk);
         chk("pwm period", tb[i][1] ? {16'h0, ta[i]} : span(tp[i]), per);
         chk("pwm high", pwm_hi(ta[i], tp[i], tb[i]), hi);
         rd(IDX_STATUS, d);
         chk("pwm flags", 32'h3, d);
      end
      setup({MODE_PWM, 2'b10, 4'b1000}, 16'd300, 8'h01);
      for (int i = 0; i < 4; i++) begin
         repeat (97) @(posedge clk);
         chk("full duty", 32'h1, lvl);
      end
      rd(IDX_STATUS, d);
      chk("P flag only", 32'h2, d);
      for (int f = 0; f < 2; f++) begin
         setup({MODE_PWM, 2'(f), 4'b1000}, 16'd64, 8'h01);
         repeat (600) @(posedge clk);
         chk("forced level", 32'(f), lvl);
         rd(IDX_STATUS, d);
         chk("forced flags", 32'h3, d);
      end
      $display("test pwm done");
      setup({MODE_TMR, 2'b00, 4'b0000}, 16'd5, 8'h00);
      chk("pin released", 32'h0, oe);
      repeat (65000) @(posedge clk);
      rd(IDX_STATUS, d);
      chk("before overflow", 32'h1, d);
      repeat (1000) @(posedge clk);
      rd(IDX_STATUS, d);
      chk("after overflow", 32'h3, d);
      wr(IDX_CTRL0, 8'h98);
      rd(IDX_CNT_LO, r);
      rd(IDX_CNT_LO, d);
      chk("paused count", r, d);
      wr(IDX_CTRL0, 8'h18);
      rd(IDX_CNT_LO, d);
      chk("resumed count", 32'h1, d != r);
      wr(IDX_CTRL0, 8'h10);
      rd(IDX_CNT_LO, r);
      rd(IDX_CNT_LO, d);
      chk("held count", r, d);
      wr(IDX_CTRL0, 8'h18);
      rd(IDX_CNT_HI, d);
      chk("restart count", 32'h0, d);
      // Window of 192 edges between the two sampling edges of the reads
      for (int s = 0; s < 8; s++) begin
         wr(IDX_CTRL0, {1'b0, 3'(s), 4'h8});
         rd(IDX_CNT_LO, r);
         repeat (189) @(posedge clk);
         rd(IDX_CNT_LO, d);
         chk("tick rate", {24'h0, ticks(3'(s))}, {24'h0, 8'(d - r)});
      end
      $display("test timer done");
      end_of_test();
   end
endmodule : tb_stcp_timer
`default_nettype wire
